/* File: design/acis_pkg.sv */
// Package for the auxiliary channel input select block.
// Assumes a 16-bit register reached over a 32-bit Avalon-MM slave.
package acis_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          ACIS_ADDR_W       = 4;
  localparam logic [3:0]  ACIS_SEL_OFFSET   = 4'h0;
  localparam logic [3:0]  ACIS_CTRL_OFFSET  = 4'h4;
  localparam logic [3:0]  ACIS_STAT_OFFSET  = 4'h8;
  localparam logic [15:0] ACIS_SEL_RESET    = 16'h0000;
  localparam logic [15:0] ACIS_SEL_MASK     = 16'h0707;
  localparam logic [31:0] ACIS_UNMAPPED_VAL = 32'h00000000;

  // Field positions in the select register
  localparam int ACIS_POS_A_BIT = 0;
  localparam int ACIS_NEG_A_LSB = 1;
  localparam int ACIS_POS_B_BIT = 8;
  localparam int ACIS_NEG_B_LSB = 9;

  // Control register bits
  localparam int ACIS_CTRL_12B_BIT = 0;
  localparam int ACIS_CTRL_ALT_BIT = 1;

  // ----------------------------------------------------------------------
  // Negative select codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] ACIS_NEG_HI_GROUP = 2'h3;
  localparam logic [1:0] ACIS_NEG_LO_GROUP = 2'h2;

  // Analog input numbers seen at each channel (channel one base)
  localparam logic [4:0] ACIS_POS_BASE_0 = 5'h00;
  localparam logic [4:0] ACIS_POS_BASE_1 = 5'h03;
  localparam logic [4:0] ACIS_NEG_BASE_L = 5'h06;
  localparam logic [4:0] ACIS_NEG_BASE_H = 5'h09;
  localparam logic [4:0] ACIS_NEG_VREF   = 5'h1f;
  localparam int         ACIS_NUM_CH     = 3;

  typedef struct packed {
    logic [1:0] neg_sel;
    logic       pos_sel;
  } acis_sample_t;

  typedef struct packed {
    logic [4:0] pos_input;
    logic [4:0] neg_input;
  } acis_route_t;

  typedef enum logic [0:0] {
    ACIS_SAMPLE_A = 1'b0,
    ACIS_SAMPLE_B = 1'b1
  } acis_phase_t;

endpackage : acis_pkg

/* File: design/acis_select.sv */
// Input selection for sample-and-hold channels one to three.
// Assumes an Avalon-MM master on clk_i and a converter that pulses
// conversion_start_i once per sample taken.
// clk_en_i must stay high while a bus transfer is in flight: with it
// low waitrequest holds its level but nothing is taken or written.
//
// What this block does
// - Positive selects at bit 0 and bit 8
// - Negative select fields bits 2:1 and 10:9
// - Negative code 11 routes inputs 9,10,11
// - Negative code 10 routes inputs 6,7,8
// - Negative code 0x routes negative reference
// - Positive select 1 routes inputs 3,4,5
// - Positive select 0 routes inputs 0,1,2
// - Twelve-bit mode hides and disables fields
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module acis_select
  import acis_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   clk_en_i,
  input  wire logic [ACIS_ADDR_W-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  input  wire logic                   conversion_start_i,
  output acis_route_t                 route_ch1_o,
  output acis_route_t                 route_ch2_o,
  output acis_route_t                 route_ch3_o,
  output logic                        sample_b_active_o
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [15:0]  sel_ff;
  logic         twelve_bit_conversion_mode_ff;
  logic         alt_sample_en_ff;
  acis_phase_t  phase_ff;
  logic         waitreq_ff;
  acis_route_t  route_ff [ACIS_NUM_CH];
  logic         req;
  logic         wr_commit;
  logic         sel_wr;
  logic         ctrl_wr;
  logic [15:0]  sel_visible;
  acis_sample_t sample_a_sel;
  acis_sample_t sample_b_sel;
  acis_sample_t active_sel;
  acis_phase_t  nxt_phase;

  // A request is taken only while waitrequest stands high
  assign req = (avs_read_i | avs_write_i) & waitreq_ff;

  // ----------------------------------------------------------------------
  // Field view
  // ----------------------------------------------------------------------
  // Fields vanish entirely in twelve-bit mode; the stored bits survive
  // and come back when the mode is left
  assign sel_visible = twelve_bit_conversion_mode_ff ? '0
                                                     : sel_ff;

  // Sample A sits in the low byte, sample B in the high byte
  assign sample_a_sel.pos_sel = sel_visible[ACIS_POS_A_BIT];
  assign sample_a_sel.neg_sel =
    sel_visible[ACIS_NEG_A_LSB +: 2];
  assign sample_b_sel.pos_sel = sel_visible[ACIS_POS_B_BIT];
  assign sample_b_sel.neg_sel =
    sel_visible[ACIS_NEG_B_LSB +: 2];

  // ----------------------------------------------------------------------
  // Routing decode
  // ----------------------------------------------------------------------
  // The channel index is added to the base input of each group
  function automatic acis_route_t acis_route(input acis_sample_t s,
                                             input logic [4:0]   ch);
    acis_route_t r;
    r.pos_input = (s.pos_sel ? ACIS_POS_BASE_1
                             : ACIS_POS_BASE_0) + ch;
    if (s.neg_sel == ACIS_NEG_HI_GROUP) begin
      r.neg_input = ACIS_NEG_BASE_H + ch;
    end else if (s.neg_sel == ACIS_NEG_LO_GROUP) begin
      r.neg_input = ACIS_NEG_BASE_L + ch;
    end else begin
      r.neg_input = ACIS_NEG_VREF;
    end
    return r;
  endfunction : acis_route

  // Word decode shared by the write and read paths
  function automatic logic acis_hit(input logic [ACIS_ADDR_W-1:0] a,
                                    input logic [ACIS_ADDR_W-1:0] off);
    return a == off;
  endfunction : acis_hit

  assign active_sel = (phase_ff == ACIS_SAMPLE_B) ? sample_b_sel
                                                   : sample_a_sel;

  // ----------------------------------------------------------------------
  // Bus handshake: one wait cycle, then the transfer completes
  // ----------------------------------------------------------------------
  // Waitrequest comes straight from a flop so the master sees a clean
  // level; every access pays one fixed wait cycle for it, which is
  // harmless at the rate software touches this register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      waitreq_ff <= 1'b1;
    end else if (clk_en_i) begin
      waitreq_ff <= ~req;
    end
  end

  assign avs_waitrequest_o = waitreq_ff;

  // Writes land on the edge at which the master sees waitrequest low
  assign wr_commit = clk_en_i & avs_write_i & ~waitreq_ff;
  assign sel_wr    = wr_commit & acis_hit(avs_address_i, ACIS_SEL_OFFSET);
  assign ctrl_wr   = wr_commit & acis_hit(avs_address_i, ACIS_CTRL_OFFSET) &
                     avs_byteenable_i[0];

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  // Stray bits are masked on the way in so they always read as zero
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sel_ff <= ACIS_SEL_RESET;
    end else if (sel_wr) begin
      // Writes are dropped in twelve-bit mode: the bits do not exist
      if (!twelve_bit_conversion_mode_ff) begin
        if (avs_byteenable_i[0]) begin
          sel_ff[7:0] <= avs_writedata_i[7:0] & ACIS_SEL_MASK[7:0];
        end
        if (avs_byteenable_i[1]) begin
          sel_ff[15:8] <= avs_writedata_i[15:8] & ACIS_SEL_MASK[15:8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      twelve_bit_conversion_mode_ff <= 1'b0;
      alt_sample_en_ff              <= 1'b0;
    end else if (ctrl_wr) begin
      twelve_bit_conversion_mode_ff <= avs_writedata_i[ACIS_CTRL_12B_BIT];
      alt_sample_en_ff              <= avs_writedata_i[ACIS_CTRL_ALT_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Registered on the taking edge, the same edge at which waitrequest
  // drops, so it already stands when the master sees waitrequest low
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= ACIS_UNMAPPED_VAL;
    end else if (clk_en_i) begin
      if (req && avs_read_i) begin
        if (acis_hit(avs_address_i, ACIS_SEL_OFFSET)) begin
          avs_readdata_o <= {16'h0000, sel_visible};
        end else if (acis_hit(avs_address_i, ACIS_CTRL_OFFSET)) begin
          avs_readdata_o <= {30'h0, alt_sample_en_ff,
                             twelve_bit_conversion_mode_ff};
        end else if (acis_hit(avs_address_i, ACIS_STAT_OFFSET)) begin
          avs_readdata_o <= {31'h0, phase_ff};
        end else begin
          avs_readdata_o <= ACIS_UNMAPPED_VAL;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sample phase
  // ----------------------------------------------------------------------
  // With alternate sampling off the phase parks on sample A, so turning
  // it on always starts a sequence with the sample A selections
  always_comb begin
    nxt_phase = phase_ff;
    if (!alt_sample_en_ff) begin
      nxt_phase = ACIS_SAMPLE_A;
    end else if (conversion_start_i) begin
      nxt_phase = (phase_ff == ACIS_SAMPLE_A) ? ACIS_SAMPLE_B
                                              : ACIS_SAMPLE_A;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      phase_ff <= ACIS_SAMPLE_A;
    end else if (clk_en_i) begin
      phase_ff <= nxt_phase;
    end
  end

  // ----------------------------------------------------------------------
  // Registered routing per channel
  // ----------------------------------------------------------------------
  // Routes are registered so the input switches see at most one change
  // per clock, at the cost of one cycle of lag behind a register write
  for (genvar g = 0; g < ACIS_NUM_CH; g++) begin : g_ch
    always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
        route_ff[g] <= '0;
      end else if (clk_en_i) begin
        route_ff[g] <= acis_route(active_sel, 5'(g));
      end
    end
  end

  assign route_ch1_o       = route_ff[0];
  assign route_ch2_o       = route_ff[1];
  assign route_ch3_o       = route_ff[2];
  assign sample_b_active_o = phase_ff;

endmodule : acis_select

/* File: sim/acis_select_chk.sv */
// Port checker for the channel one to three input select block.
// Assumes binding to acis_select with its clock and reset.
`timescale 1ns/10ps
module acis_chk
  import acis_pkg::*;
(
  input wire logic                   clk_i,
  input wire logic                   resetn_i,
  input wire logic [ACIS_ADDR_W-1:0] avs_address_i,
  input wire logic                   avs_read_i,
  input wire logic                   avs_write_i,
  input wire logic [31:0]            avs_readdata_o,
  input wire logic                   avs_waitrequest_o,
  input wire logic                   conversion_start_i,
  input wire acis_route_t            route_ch1_o,
  input wire acis_route_t            route_ch2_o,
  input wire acis_route_t            route_ch3_o,
  input wire logic                   sample_b_active_o
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Routes hold zero for one edge after release, hence the past term
  AST_POS_BASE: assert property ($past(resetn_i) |->
    route_ch1_o.pos_input inside {5'h00, 5'h03}) else $error("pos base");
  AST_POS_STEP: assert property ($past(resetn_i) |->
    route_ch2_o.pos_input == route_ch1_o.pos_input + 5'h01 &&
    route_ch3_o.pos_input == route_ch1_o.pos_input + 5'h02)
    else $error("pos step");
  AST_NEG_BASE: assert property ($past(resetn_i) |->
    route_ch1_o.neg_input inside {5'h06, 5'h09, 5'h1f})
    else $error("neg base");
  AST_NEG_STEP: assert property ($past(resetn_i) &&
    route_ch1_o.neg_input != 5'h1f |->
    route_ch3_o.neg_input == route_ch1_o.neg_input + 5'h02)
    else $error("neg step");
  AST_NEG_REF: assert property (route_ch1_o.neg_input == 5'h1f |->
    route_ch2_o.neg_input == 5'h1f && route_ch3_o.neg_input == 5'h1f)
    else $error("neg ref");
  AST_ACK: assert property ($rose(avs_read_i || avs_write_i) |=>
    !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("ack timing");
  AST_RD_MASK: assert property (
    avs_read_i && !avs_waitrequest_o |->
    (avs_readdata_o & 32'hfffff8f8) == 32'h0) else $error("read mask");
  AST_UNMAP: assert property (avs_read_i && !avs_waitrequest_o &&
    !(avs_address_i inside {4'h0, 4'h4, 4'h8}) |->
    avs_readdata_o == 32'h0) else $error("unmapped read");
  AST_PHASE: assert property ($rose(sample_b_active_o) |->
    $past(conversion_start_i)) else $error("phase without start");
  COV_HI: cover property (route_ch1_o.neg_input == 5'h09);
  COV_B: cover property ($fell(sample_b_active_o));
  COV_WR: cover property (avs_write_i && !avs_waitrequest_o);
endmodule : acis_chk

bind acis_select acis_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .route_ch1_o(route_ch1_o),
  .conversion_start_i(conversion_start_i), .route_ch2_o(route_ch2_o),
  .route_ch3_o(route_ch3_o), .sample_b_active_o(sample_b_active_o));

/* File: sim/acis_select_tb.sv */
// Self-checking bench for acis_select against an integer model.
// Assumes the bind of acis_chk is compiled alongside.
`timescale 1ns/10ps
module acis_select_tb
  import acis_pkg::*;
;
  logic        clk_i = 1'b0, resetn_i = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        cs = 1'b0, en = 1'b1, wq, ph;
  logic [3:0]  adr = 4'h0, be = 4'h0;
  logic [31:0] wd = 32'h0, q, rdat, seed = 32'h4a, r;
  acis_route_t r1, r2, r3;
  int          bad_count = 0, checked = 0, sel_m = 0, ctrl_m = 0, ph_m = 0;
  acis_select dut (.clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(en),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .conversion_start_i(cs), .route_ch1_o(r1),
    .route_ch2_o(r2), .route_ch3_o(r3), .sample_b_active_o(ph));
  always #50 clk_i = ~clk_i;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic int rte();
    int f, r;
    f = (ctrl_m & 1) ? 0 : ((ctrl_m & 2) && ph_m) ? sel_m >> 8 : sel_m;
    r = 0;
    for (int c = 0; c < 3; c++) begin
      r = (r << 10) | (((f & 1) ? 3 + c : c) << 5);
      r = r | ((f & 4) ? ((f & 2) ? 9 : 6) + c : 31);
    end
    return r;
  endfunction : rte
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    @(posedge clk_i);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    be <= b;
    do @(posedge clk_i); while (wq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic wt(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] b);
    bus(1'b1, a, d, b);
    // Select writes are dropped while twelve-bit mode is set
    if (a == 4'h0 && !(ctrl_m & 1) && b[0]) sel_m = sel_m & 'h700 | d & 7;
    if (a == 4'h0 && !(ctrl_m & 1) && b[1]) sel_m = sel_m & 7 | d & 'h700;
    if (a == 4'h4 && b[0]) ctrl_m = d & 3;
    if (!(ctrl_m & 2)) ph_m = 0;
  endtask : wt
  task automatic rdc(input logic [3:0] a);
    bus(1'b0, a, xs(), 4'hf);
    chk(q, a == 4'h0 ? ((ctrl_m & 1) ? 0 : sel_m) : a == 4'h4 ? ctrl_m :
        a == 4'h8 ? ph_m : 0);
    chk({2'h0, r1, r2, r3}, rte());
    chk({31'h0, ph}, ph_m);
  endtask : rdc
  task automatic print_verdict();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    rdc(4'h0);
    // Every A and B code, then random lanes; stray bits must read zero
    for (int i = 0; i < 72; i++) begin
      r = xs();
      wt(4'h0, r & 32'hfffff8f8 | ((i >> 3) & 7) << 8 | i & 7,
         i < 64 ? 4'hf : r[7:4]);
      rdc(4'h0);
    end
    wt(4'h4, 32'h1, 4'hf);
    rdc(4'h0);
    wt(4'h0, 32'h0707, 4'hf);
    rdc(4'h4);
    wt(4'h4, 32'h0, 4'hf);
    rdc(4'h0);
    wt(4'h0, 32'h0605, 4'hf);
    wt(4'h4, 32'h2, 4'hf);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i) cs <= 1'b1;
      @(posedge clk_i) cs <= 1'b0;
      ph_m ^= 1;
      rdc(4'h8);
    end
    // A start pulse while the clock enable is low must not move the phase
    @(posedge clk_i) en <= 1'b0;
    @(posedge clk_i) cs <= 1'b1;
    @(posedge clk_i) cs <= 1'b0;
    en <= 1'b1;
    rdc(4'h8);
    wt(4'h4, 32'h0, 4'hf);
    rdc(4'h8);
    wt(4'hc, xs(), 4'hf);
    rdc(4'hc);
    rdc(4'h0);
    // Mid-run reset with sample B active must clear every register
    wt(4'h4, 32'h2, 4'hf);
    @(posedge clk_i) cs <= 1'b1;
    @(posedge clk_i) cs <= 1'b0;
    ph_m ^= 1;
    rdc(4'h8);
    @(posedge clk_i) resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    sel_m = 0;
    ctrl_m = 0;
    ph_m = 0;
    rdc(4'h8);
    rdc(4'h0);
    rdc(4'h4);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end
endmodule : acis_select_tb
